/* hdl/ext_area_pkg.sv */
package ext_area_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_COMMON_CTRL = 8'h00;
  localparam logic [7:0] OFS_AREA3_CFG = 8'h04;
  localparam logic [7:0] OFS_AREA4_CFG = 8'h08;
  localparam logic [7:0] OFS_AREA5_CFG = 8'h0c;
  localparam logic [7:0] OFS_AREA6_CFG = 8'h10;
  localparam logic [7:0] OFS_DECODE_STAT = 8'h14;
  // ---------------------------------------------------------------
  // common control fields
  // ---------------------------------------------------------------
  localparam int BIT_MAP = 12;
  localparam int BIT_ENDIAN = 3;
  localparam int BIT_RSV_ONE_HI = 4;
  localparam int BIT_RSV_ONE_LO = 2;
  localparam int BIT_HIZ_MEM = 1;
  localparam int BIT_HIZ_CNT = 0;
  localparam logic RST_MAP = 1'b0;
  localparam logic RST_HIZ = 1'b0;
  // ---------------------------------------------------------------
  // per-area config fields: [1:0] width, [3:2] memory type
  // ---------------------------------------------------------------
  localparam int CFG_WIDTH_LSB = 0;
  localparam int CFG_TYPE_LSB = 2;
  localparam logic [3:0] RST_AREA_CFG = 4'h0;
  // width codes
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  localparam int AREA_MSB = 28;
  localparam int AREA_LSB = 25;
  localparam logic [2:0] REGION_INTERNAL_IO = 3'h7;
  // area codes (binary; chip select index is code minus one)
  typedef enum logic [2:0] {
    AREA_NONE, AREA_0, AREA_3, AREA_4, AREA_5, AREA_6
  } area_t;
  localparam int NUM_CS = 5;
endpackage

/* hdl/area_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// combinational map from physical address to an area
module area_decode (
  input wire logic [31:0] i_addr,
  input wire logic i_map_sel,
  output ext_area_pkg::area_t o_area
);
  logic [3:0] code;
  logic internal;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // top bits only flag internal space, never shadowing
  assign code = i_addr[ext_area_pkg::AREA_MSB:ext_area_pkg::AREA_LSB];
  assign internal = (i_addr[31:29] == ext_area_pkg::REGION_INTERNAL_IO);

  always_comb begin
    o_area = ext_area_pkg::AREA_NONE;
    if (internal) begin
      o_area = ext_area_pkg::AREA_NONE;
    end else if (code[3:1] == 3'h0) begin
      o_area = ext_area_pkg::AREA_0;
    end else if (code[3:1] == 3'h3) begin
      o_area = ext_area_pkg::AREA_3;
    end else if (code[3:1] == 3'h4) begin
      o_area = ext_area_pkg::AREA_4;
    end else if (code[3:1] == 3'h5) begin
      // map 1 keeps only upper half (5B); map 2 uses whole area
      if (i_map_sel || code[0]) begin
        o_area = ext_area_pkg::AREA_5;
      end
    end else if (code[3:1] == 3'h6) begin
      // same split for area 6: lower half reserved unless map bit set
      if (i_map_sel || code[0]) begin
        o_area = ext_area_pkg::AREA_6;
      end
    end
    // codes 1, 2 and 7 fall through: areas 1, 2 and 7 are reserved
  end
endmodule
`default_nettype wire

/* hdl/external_bus_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module external_bus_controller (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // cpu access request
  input wire logic i_acc_valid,
  input wire logic [31:0] i_acc_addr,
  // strap pins
  input wire logic i_area0_width_strap,
  input wire logic i_endian_strap,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // chip selects, active low
  output logic o_area0_chip_select_n,
  output logic o_area3_chip_select_n,
  output logic o_area4_chip_select_n,
  output logic o_area5_chip_select_n,
  output logic o_area6_chip_select_n,
  // per access attributes (width, type) and static mode outputs
  output logic [1:0] o_bus_width,
  output logic [1:0] o_mem_type,
  output logic o_little_endian,
  output logic o_map_sel,
  output logic o_hiz_mem,
  output logic o_hiz_cnt
);
  // ---------------------------------------------------------------
  // strap synchronisers and power-on capture
  // ---------------------------------------------------------------
  logic [1:0] width_sync_r;
  logic [1:0] endian_sync_r;
  logic strap_taken_r;
  logic [1:0] fill_r;
  logic area0_is_8bit_r;
  logic little_endian_r;

  // two flops each, strap pins are asynchronous
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      width_sync_r <= 2'h0;
      endian_sync_r <= 2'h0;
    end else begin
      width_sync_r <= {width_sync_r[0], i_area0_width_strap};
      endian_sync_r <= {endian_sync_r[0], i_endian_strap};
    end
  end

  // marks when the pin level has crossed both sync flops; comparing
  // the two sync flops instead would accept the reset zeros as a level
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fill_r <= 2'h0;
    end else begin
      fill_r <= {fill_r[0], 1'b1};
    end
  end

  // catch straps once after release; later pin changes are ignored
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_taken_r <= 1'b0;
      area0_is_8bit_r <= 1'b0;
      little_endian_r <= 1'b0;
    end else if (!strap_taken_r && fill_r[1]) begin
      // third edge after release: second flop holds the real pin level
      strap_taken_r <= 1'b1;
      area0_is_8bit_r <= width_sync_r[1];
      little_endian_r <= endian_sync_r[1];
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic map_r;
  logic hiz_mem_r;
  logic hiz_cnt_r;
  logic [3:0] area_cfg_r [2:5];

  // common control register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      map_r <= ext_area_pkg::RST_MAP;
      hiz_mem_r <= ext_area_pkg::RST_HIZ;
      hiz_cnt_r <= ext_area_pkg::RST_HIZ;
    end else if (i_reg_wr && i_reg_addr == ext_area_pkg::OFS_COMMON_CTRL) begin
      map_r <= i_reg_wdata[ext_area_pkg::BIT_MAP];
      hiz_mem_r <= i_reg_wdata[ext_area_pkg::BIT_HIZ_MEM];
      hiz_cnt_r <= i_reg_wdata[ext_area_pkg::BIT_HIZ_CNT];
    end
  end

  // per-area config words; index 2..5 = areas 3, 4, 5(B), 6(B)
  genvar g;
  generate
    for (g = 2; g <= 5; g++) begin : g_cfg
      localparam logic [7:0] OFS = ext_area_pkg::OFS_AREA3_CFG +
                                   8'((g - 2) * 4);
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          area_cfg_r[g] <= ext_area_pkg::RST_AREA_CFG;
        end else if (i_reg_wr && i_reg_addr == OFS) begin
          area_cfg_r[g] <= i_reg_wdata[3:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  ext_area_pkg::area_t area;
  ext_area_pkg::area_t area_fix;
  logic [31:0] probe_addr;
  logic [ext_area_pkg::NUM_CS-1:0] sel_nxt;

  assign probe_addr = i_acc_addr;

  area_decode u_dec (
    .i_addr(probe_addr),
    .i_map_sel(map_r),
    .o_area(area)
  );

  // the decoder folds shadows, the map bit and reserved holes itself
  assign area_fix = area;

  // one select request per usable area, in enum order 0, 3, 4, 5, 6;
  // a reserved or internal access leaves every bit low
  genvar k;
  generate
    for (k = 0; k < ext_area_pkg::NUM_CS; k++) begin : g_sel
      // usable areas sit at enum codes 1 to 5, code 0 is no area
      assign sel_nxt[k] = i_acc_valid &&
        (area_fix == ext_area_pkg::area_t'(k + 1));
    end
  endgenerate

  // ---------------------------------------------------------------
  // registered access outputs
  // ---------------------------------------------------------------
  logic [1:0] width_nxt;
  logic [1:0] type_nxt;

  // area 5/6 use the 5B/6B settings in both maps
  always_comb begin
    width_nxt = 2'h0;
    type_nxt = 2'h0;
    case (area_fix)
      ext_area_pkg::AREA_0: begin
        width_nxt = area0_is_8bit_r ? ext_area_pkg::WIDTH_8 :
                    ext_area_pkg::WIDTH_16;
      end
      ext_area_pkg::AREA_3: begin
        width_nxt = area_cfg_r[2][1:0];
        type_nxt = area_cfg_r[2][3:2];
      end
      ext_area_pkg::AREA_4: begin
        width_nxt = area_cfg_r[3][1:0];
        type_nxt = area_cfg_r[3][3:2];
      end
      ext_area_pkg::AREA_5: begin
        width_nxt = area_cfg_r[4][1:0];
        type_nxt = area_cfg_r[4][3:2];
      end
      ext_area_pkg::AREA_6: begin
        width_nxt = area_cfg_r[5][1:0];
        type_nxt = area_cfg_r[5][3:2];
      end
      default: begin
        width_nxt = 2'h0;
        type_nxt = 2'h0;
      end
    endcase
  end

  // chip selects and attributes one cycle after the request
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_area0_chip_select_n <= 1'b1;
      o_area3_chip_select_n <= 1'b1;
      o_area4_chip_select_n <= 1'b1;
      o_area5_chip_select_n <= 1'b1;
      o_area6_chip_select_n <= 1'b1;
      o_bus_width <= 2'h0;
      o_mem_type <= 2'h0;
    end else begin
      o_area0_chip_select_n <= !sel_nxt[0];
      o_area3_chip_select_n <= !sel_nxt[1];
      o_area4_chip_select_n <= !sel_nxt[2];
      o_area5_chip_select_n <= !sel_nxt[3];
      o_area6_chip_select_n <= !sel_nxt[4];
      o_bus_width <= i_acc_valid ? width_nxt : 2'h0;
      o_mem_type <= i_acc_valid ? type_nxt : 2'h0;
    end
  end

  // static mode outputs
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_little_endian <= 1'b0;
      o_map_sel <= 1'b0;
      o_hiz_mem <= 1'b0;
      o_hiz_cnt <= 1'b0;
    end else begin
      o_little_endian <= little_endian_r;
      o_map_sel <= map_r;
      o_hiz_mem <= hiz_mem_r;
      o_hiz_cnt <= hiz_cnt_r;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [31:0] rdata_nxt;

  // reserved bits read 0 except the two fixed ones
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (i_reg_addr == ext_area_pkg::OFS_COMMON_CTRL) begin
      rdata_nxt[ext_area_pkg::BIT_MAP] = map_r;
      rdata_nxt[ext_area_pkg::BIT_RSV_ONE_HI] = 1'b1;
      rdata_nxt[ext_area_pkg::BIT_ENDIAN] = little_endian_r;
      rdata_nxt[ext_area_pkg::BIT_RSV_ONE_LO] = 1'b1;
      rdata_nxt[ext_area_pkg::BIT_HIZ_MEM] = hiz_mem_r;
      rdata_nxt[ext_area_pkg::BIT_HIZ_CNT] = hiz_cnt_r;
    end else if (i_reg_addr == ext_area_pkg::OFS_AREA3_CFG) begin
      rdata_nxt[3:0] = area_cfg_r[2];
    end else if (i_reg_addr == ext_area_pkg::OFS_AREA4_CFG) begin
      rdata_nxt[3:0] = area_cfg_r[3];
    end else if (i_reg_addr == ext_area_pkg::OFS_AREA5_CFG) begin
      rdata_nxt[3:0] = area_cfg_r[4];
    end else if (i_reg_addr == ext_area_pkg::OFS_AREA6_CFG) begin
      rdata_nxt[3:0] = area_cfg_r[5];
    end else if (i_reg_addr == ext_area_pkg::OFS_DECODE_STAT) begin
      // live decode of current request, plus strap state
      rdata_nxt[2:0] = area_fix;
      rdata_nxt[8] = area0_is_8bit_r;
      rdata_nxt[9] = strap_taken_r;
    end
  end

  // data valid only the cycle after the strobe; otherwise zero
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      o_reg_rdata <= i_reg_rd ? rdata_nxt : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* dv/ext_bus_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_bus_sva (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_acc_valid,
  input wire logic [31:0] i_acc_addr,
  input wire logic i_area0_width_strap,
  input wire logic i_endian_strap,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_area0_chip_select_n,
  input wire logic o_area3_chip_select_n,
  input wire logic o_area4_chip_select_n,
  input wire logic o_area5_chip_select_n,
  input wire logic o_area6_chip_select_n,
  input wire logic [1:0] o_bus_width,
  input wire logic o_little_endian,
  input wire logic o_map_sel
);
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  logic [4:0] cs_n;
  logic [3:0] code;
  logic ext;
  logic [2:0] age_r;
  assign cs_n = {o_area6_chip_select_n, o_area5_chip_select_n,
    o_area4_chip_select_n, o_area3_chip_select_n, o_area0_chip_select_n};
  assign code = i_acc_addr[28:25];
  assign ext = i_acc_valid && (i_acc_addr[31:29] != 3'h7);
  // edges since reset; straps need a few edges to settle
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  property p_cs0; ext && code[3:1] == 3'h0 |=> cs_n == 5'h1e; endproperty
  a_cs0: assert property (p_cs0)
    else $error("area 0 select wrong");
  property p_cs3; ext && code[3:1] == 3'h3 |=> cs_n == 5'h1d; endproperty
  a_cs3: assert property (p_cs3)
    else $error("area 3 select wrong");
  property p_cs4; ext && code[3:1] == 3'h4 |=> cs_n == 5'h1b; endproperty
  a_cs4: assert property (p_cs4)
    else $error("area 4 select wrong");
  // upper halves select in either map
  property p_half;
    ext && (code == 4'hb || code == 4'hd) |=>
      cs_n == (($past(code) == 4'hb) ? 5'h17 : 5'h0f);
  endproperty
  a_half: assert property (p_half)
    else $error("half area select wrong");
  // o_map_sel lags the map bit one edge, so it is read one edge later
  property p_wide;
    ext && (code == 4'ha || code == 4'hc) |=> o_map_sel ?
      cs_n == (($past(code) == 4'ha) ? 5'h17 : 5'h0f) : &cs_n;
  endproperty
  a_wide: assert property (p_wide)
    else $error("full area select wrong");
  property p_none;
    !i_acc_valid || i_acc_addr[31:29] == 3'h7 ||
      code inside {[4'h2:4'h5], 4'he, 4'hf} |=> &cs_n;
  endproperty
  a_none: assert property (p_none)
    else $error("select on reserved access");
  property p_one; $countones(~cs_n) <= 1; endproperty
  a_one: assert property (p_one)
    else $error("two selects at once");
  // ----------------------------------------------------------
  // straps and control
  // ----------------------------------------------------------
  property p_width;
    !o_area0_chip_select_n && age_r == 3'h7 |-> o_bus_width ==
      (i_area0_width_strap ? ext_area_pkg::WIDTH_8 : ext_area_pkg::WIDTH_16);
  endproperty
  a_width: assert property (p_width)
    else $error("area 0 width wrong");
  property p_endian; age_r == 3'h7 |-> o_little_endian == i_endian_strap;
  endproperty
  a_endian: assert property (p_endian)
    else $error("endian wrong");
  property p_ctrl;
    i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rdata[12] == o_map_sel &&
      o_reg_rdata[4:2] == {1'b1, o_little_endian, 1'b1};
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control read wrong");
endmodule
`default_nettype wire

/* dv/ext_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [4:0] i_cs_n,
  output logic o_clash
);
  // parts share data lines; two selected at once means contention
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) o_clash <= 1'b0;
    else if ($countones(~i_cs_n) > 1) o_clash <= 1'b1;
  end
endmodule
`default_nettype wire

/* dv/test_external_bus_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module test_external_bus_controller;
  logic i_ref_clk, i_rst, i_acc_valid, i_reg_wr, i_reg_rd, o_clash;
  logic i_area0_width_strap, i_endian_strap;
  logic [31:0] i_acc_addr, i_reg_wdata, o_reg_rdata;
  logic [7:0] i_reg_addr;
  logic o_area0_chip_select_n, o_area3_chip_select_n;
  logic o_area4_chip_select_n, o_area5_chip_select_n;
  logic o_area6_chip_select_n, o_little_endian, o_map_sel;
  logic o_hiz_mem, o_hiz_cnt;
  logic [1:0] o_bus_width, o_mem_type;
  logic [4:0] cs;
  int errors, checked, cycles;
  assign cs = {o_area6_chip_select_n, o_area5_chip_select_n,
    o_area4_chip_select_n, o_area3_chip_select_n, o_area0_chip_select_n};
  external_bus_controller u_external_bus_controller (.i_ref_clk, .i_rst,
    .i_acc_valid, .i_acc_addr, .i_area0_width_strap, .i_endian_strap,
    .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .o_area0_chip_select_n, .o_area3_chip_select_n, .o_area4_chip_select_n,
    .o_area5_chip_select_n, .o_area6_chip_select_n, .o_bus_width,
    .o_mem_type, .o_little_endian, .o_map_sel, .o_hiz_mem, .o_hiz_cnt);
  ext_mem_model u_ext_mem_model (.i_ref_clk, .i_rst, .i_cs_n(cs), .o_clash);
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [4:0] exp_cs(input logic [31:0] a, input logic m);
    exp_cs = 5'h1f;
    if (a[31:29] != 3'h7) case (a[28:25])
      4'h0, 4'h1: exp_cs = 5'h1e;
      4'h6, 4'h7: exp_cs = 5'h1d;
      4'h8, 4'h9: exp_cs = 5'h1b;
      4'ha: if (m) exp_cs = 5'h17;
      4'hb: exp_cs = 5'h17;
      4'hc: if (m) exp_cs = 5'h0f;
      4'hd: exp_cs = 5'h0f;
      default: ;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata, exp);
  endtask
  // request stays up afterwards; a held request simply repeats
  task automatic acc(input logic [31:0] a, input logic m);
    @(posedge i_ref_clk);
    i_acc_valid <= 1'b1;
    i_acc_addr <= a;
    @(posedge i_ref_clk);
    #1 chk({27'h0, cs}, {27'h0, exp_cs(a, m)});
  endtask
  task automatic sweep(input logic m);
    for (int i = 0; i < 16; i++) acc({i[2:0], i[3:0], 25'h0_1234}, m);
    @(posedge i_ref_clk);
    i_acc_valid <= 1'b0;
  endtask
  task automatic attr(input logic [3:0] exp);
    chk({28'h0, o_bus_width, o_mem_type}, {28'h0, exp});
  endtask
  task automatic do_reset;
    i_rst <= 1'b1;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
  endtask
  task automatic wrap_up;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  // a hang ends the run rather than the simulator limit
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    {i_rst, i_acc_valid, i_reg_wr, i_reg_rd} = 4'h8;
    {i_area0_width_strap, i_endian_strap} = 2'h3;
    {i_acc_addr, i_reg_wdata, i_reg_addr} = '0;
    do_reset();
    reg_rd(8'h00, 32'h0000_001c);
    reg_rd(8'h40, 32'h0000_0000);
    acc(32'h0000_0000, 1'b0);
    attr({ext_area_pkg::WIDTH_8, 2'h0});
    reg_rd(8'h14, 32'h0000_0301);
    $display("test straps done");
    sweep(1'b0);
    $display("test map0 done");
    reg_wr(8'h04, 32'h0000_000a);
    acc(32'h0c00_0000, 1'b0);
    attr(4'ha);
    reg_wr(8'h00, 32'h0000_1000);
    reg_rd(8'h00, 32'h0000_101c);
    chk({31'h0, o_map_sel}, 32'h0000_0001);
    sweep(1'b1);
    reg_wr(8'h0c, 32'h0000_0005);
    reg_wr(8'h10, 32'h0000_0006);
    acc(32'h3400_0000, 1'b1);
    attr(4'h5);
    acc(32'h1800_0000, 1'b1);
    attr(4'h9);
    $display("test map1 done");
    reg_wr(8'h00, 32'h0000_000b);
    reg_rd(8'h00, 32'h0000_001f);
    chk({30'h0, o_hiz_mem, o_hiz_cnt}, 32'h0000_0003);
    acc(32'h1400_0000, 1'b0);
    {i_area0_width_strap, i_endian_strap} <= 2'h0;
    do_reset();
    reg_rd(8'h00, 32'h0000_0014);
    reg_rd(8'h04, 32'h0000_0000);
    acc(32'h0000_0000, 1'b0);
    attr({ext_area_pkg::WIDTH_16, 2'h0});
    chk({31'h0, o_clash}, 32'h0000_0000);
    chk({30'h0, o_hiz_mem, o_hiz_cnt}, 32'h0000_0000);
    $display("test second reset done");
    wrap_up();
  end
endmodule
bind external_bus_controller ext_bus_sva u_ext_bus_sva (.i_ref_clk, .i_rst,
  .i_acc_valid, .i_acc_addr, .i_area0_width_strap, .i_endian_strap,
  .i_reg_addr, .i_reg_rd, .o_reg_rdata, .o_area0_chip_select_n,
  .o_area3_chip_select_n, .o_area4_chip_select_n, .o_area5_chip_select_n,
  .o_area6_chip_select_n, .o_bus_width, .o_little_endian, .o_map_sel);
`default_nettype wire
